// *** pkg/cpu_regs_pkg.sv ***
package cpu_regs_pkg;

    // ------------------------------------------------------------
    // Widths and bank layout
    // ------------------------------------------------------------
    localparam int WORD_W = 16;
    localparam int ADDR_W = 20;
    localparam int FLAG_W = 11;
    localparam int BANKS = 2;
    localparam int BANK_REGS = 7;
    localparam int NUM_ARCH_REGS = 13;

    // Slot of each banked register inside one bank
    localparam logic [2:0] IDX_D0 = 3'h0;
    localparam logic [2:0] IDX_D1 = 3'h1;
    localparam logic [2:0] IDX_D2 = 3'h2;
    localparam logic [2:0] IDX_D3 = 3'h3;
    localparam logic [2:0] IDX_A0 = 3'h4;
    localparam logic [2:0] IDX_A1 = 3'h5;
    localparam logic [2:0] IDX_FB = 3'h6;

    // ------------------------------------------------------------
    // Flag register layout and reset values
    // ------------------------------------------------------------
    localparam int FLAG_CARRY = 0;
    localparam int FLAG_DEBUG = 1;
    localparam int FLAG_ZERO = 2;
    localparam int FLAG_SIGN = 3;
    localparam int FLAG_BANK = 4;
    localparam int FLAG_OVF = 5;
    localparam int FLAG_INTEN = 6;
    localparam int FLAG_STACK = 7;
    localparam int FLAG_IPL_LSB = 8;
    localparam logic [10:0] FLAG_RESET = 11'h000;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [19:0] ADDR_RESET = 20'h00000;

    // ------------------------------------------------------------
    // APB byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_BANK0 = 8'h00;
    localparam logic [7:0] OFS_BANK1 = 8'h20;
    localparam logic [7:0] OFS_VECTOR = 8'h40;
    localparam logic [7:0] OFS_PC = 8'h44;
    localparam logic [7:0] OFS_USP = 8'h48;
    localparam logic [7:0] OFS_ISP = 8'h4C;
    localparam logic [7:0] OFS_SB = 8'h50;
    localparam logic [7:0] OFS_FLAGS = 8'h54;
    localparam logic [7:0] OFS_SP = 8'h58;
    localparam logic [7:0] OFS_PAIR_LO = 8'h5C;
    localparam logic [7:0] OFS_PAIR_HI = 8'h60;
    localparam logic [7:0] OFS_ADDR_PAIR = 8'h64;

    typedef enum logic [4:0] {
        OPD_D0 = 5'h00, OPD_D1 = 5'h01, OPD_D2 = 5'h02, OPD_D3 = 5'h03,
        OPD_A0 = 5'h04, OPD_A1 = 5'h05, OPD_FB = 5'h06, OPD_SB = 5'h07,
        OPD_USP = 5'h08, OPD_ISP = 5'h09, OPD_SP = 5'h0A, OPD_VECTOR = 5'h0B,
        OPD_PC = 5'h0C, OPD_FLAGS = 5'h0D, OPD_D0_LO = 5'h0E, OPD_D0_HI = 5'h0F,
        OPD_D1_LO = 5'h10, OPD_D1_HI = 5'h11, OPD_PAIR_LO = 5'h12,
        OPD_PAIR_HI = 5'h13, OPD_ADDR_PAIR = 5'h14
    } operand_t;

    typedef enum logic [1:0] {
        SIZE_BYTE = 2'h0,
        SIZE_WORD = 2'h1,
        SIZE_LONG = 2'h2
    } opsize_t;

    typedef enum logic [1:0] {
        APB_IDLE = 2'b01,
        APB_ACCESS = 2'b10
    } apb_state_t;

endpackage

// *** design/flag_calc.sv ***
`timescale 1ns/1ns
module flag_calc (
    input wire cpu_regs_pkg::opsize_t size,
    input wire logic [31:0] result,
    output logic zero,
    output logic sign
);
    import cpu_regs_pkg::*;

    // ------------------------------------------------------------
    // Zero and sign of a result at the operation's own width
    // ------------------------------------------------------------
    always_comb begin
        unique case (size)
            SIZE_BYTE: begin
                zero = (result[7:0] == 8'h00);
                sign = result[7];
            end
            SIZE_WORD: begin
                zero = (result[15:0] == 16'h0000);
                sign = result[15];
            end
            default: begin
                // Code 3 is illegal; treated as a long result
                zero = (result == 32'h00000000);
                sign = result[31];
            end
        endcase
    end
endmodule

// *** design/cpu_register_file.sv ***
// Operation
// RULE1 - thirteen architectural registers per bank view
// RULE2 - data, address, frame base duplicated per bank
// RULE3 - data 16 bits, first two byte-split
// RULE4 - third/fourth data pair with first/second
// RULE5 - address registers 16 bits, general operands
// RULE6 - two address registers form 32-bit pair
// RULE7 - frame base 16 bits, frame-relative base
// RULE8 - vector table base 20 bits wide
// RULE9 - program counter 20 bits, next instruction
// RULE10 - stack flag picks user or interrupt pointer
// RULE11 - static base 16 bits wide
// RULE12 - flag register 11 bits of state
// RULE13 - carry captures carry, borrow, shifted bit
// RULE14 - software keeps debug flag zero
// RULE15 - zero flag set on zero result
// RULE16 - sign flag set on negative result
// RULE17 - bank flag selects bank zero or one
// RULE18 - overflow flag set on overflow
// RULE19 - flag positions and reset values defined
//
// The APB register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
module cpu_register_file #(
    parameter logic [19:0] PC_RESET = 20'h00000
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire cpu_regs_pkg::operand_t dpRdSel,
    output logic [31:0] dpRdData,
    input wire logic dpWrEn,
    input wire cpu_regs_pkg::operand_t dpWrSel,
    input wire logic [31:0] dpWrData,
    input wire logic aluFlagEn,
    input wire cpu_regs_pkg::opsize_t aluSize,
    input wire logic [31:0] aluResult,
    input wire logic aluCarry,
    input wire logic aluOverflow,
    input wire logic pcLoad,
    input wire logic [19:0] pcValue,
    input wire logic pcAdvance,
    input wire logic [2:0] pcStep,
    output logic [19:0] programCounter,
    output logic [10:0] cpuFlags
);
    import cpu_regs_pkg::*;

    if (BANKS * BANK_REGS - BANK_REGS + 6 != NUM_ARCH_REGS) begin : g_layout_check
        $error("bank layout does not give the architectural count");
    end

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [15:0] bankReg [BANKS][BANK_REGS]; // RULE2
    logic [15:0] next_bankReg [BANKS][BANK_REGS];
    logic [15:0] userSp, interruptSp, staticBase;
    logic [15:0] next_userSp, next_interruptSp, next_staticBase;
    logic [19:0] vectorBase, next_vectorBase;
    logic [10:0] next_flags;
    logic [15:0] activeSp;
    apb_state_t apbState;
    logic bank;
    logic resZero, resSign;
    logic apbHit, apbWr, apbSetup;
    logic [31:0] apbRdWord, apbMerged;

    assign bank = cpuFlags[FLAG_BANK]; // RULE17
    assign apbSetup = psel && !penable;
    assign apbWr = psel && penable && pready && pwrite && !pslverr;
    assign activeSp = cpuFlags[FLAG_STACK] ? interruptSp : userSp; // RULE10

    flag_calc flagCalc (
        .size(aluSize),
        .result(aluResult),
        .zero(resZero),
        .sign(resSign)
    );

    // ------------------------------------------------------------
    // APB address decode and read view
    // ------------------------------------------------------------
    always_comb begin
        apbHit = 1'b1;
        apbRdWord = 32'h00000000;
        if (paddr[1:0] != 2'h0) begin
            apbHit = 1'b0;
        end else if (paddr[7:6] == 2'h0) begin
            if (paddr[4:2] == 3'h7) begin
                apbHit = 1'b0;
            end else begin
                apbRdWord = {16'h0000, bankReg[paddr[5]][paddr[4:2]]};
            end
        end else begin
            unique case (paddr)
                OFS_VECTOR: apbRdWord = {12'h000, vectorBase};
                OFS_PC: apbRdWord = {12'h000, programCounter};
                OFS_USP: apbRdWord = {16'h0000, userSp};
                OFS_ISP: apbRdWord = {16'h0000, interruptSp};
                OFS_SB: apbRdWord = {16'h0000, staticBase};
                OFS_FLAGS: apbRdWord = {21'h000000, cpuFlags};
                OFS_SP: apbRdWord = {16'h0000, activeSp};
                OFS_PAIR_LO: apbRdWord = {bankReg[bank][IDX_D2], bankReg[bank][IDX_D0]};
                OFS_PAIR_HI: apbRdWord = {bankReg[bank][IDX_D3], bankReg[bank][IDX_D1]};
                OFS_ADDR_PAIR: apbRdWord = {bankReg[bank][IDX_A1], bankReg[bank][IDX_A0]};
                default: apbHit = 1'b0;
            endcase
        end
    end

    // Lanes with a clear strobe keep the register's own byte
    for (genvar i = 0; i < 4; i++) begin : g_lane
        assign apbMerged[8*i +: 8] = pstrb[i] ? pwdata[8*i +: 8] : apbRdWord[8*i +: 8];
    end

    // ------------------------------------------------------------
    // APB response: one wait-free access phase
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!resetn) begin
            apbState <= APB_IDLE;
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            unique case (apbState)
                APB_IDLE: begin
                    if (apbSetup) begin
                        apbState <= APB_ACCESS;
                        pready <= 1'b1;
                        // PC is read-only from the bus
                        pslverr <= !apbHit || (pwrite && paddr == OFS_PC); // RULE9
                        prdata <= (apbHit && !pwrite) ? apbRdWord : 32'h00000000;
                    end
                end
                APB_ACCESS: begin
                    apbState <= APB_IDLE;
                    pready <= 1'b0;
                    pslverr <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Next register values: ALU flags, then datapath, then bus
    // ------------------------------------------------------------
    always_comb begin
        next_bankReg = bankReg;
        next_userSp = userSp;
        next_interruptSp = interruptSp;
        next_staticBase = staticBase;
        next_vectorBase = vectorBase;
        next_flags = cpuFlags;
        if (aluFlagEn) begin
            next_flags[FLAG_CARRY] = aluCarry; // RULE13
            next_flags[FLAG_ZERO] = resZero; // RULE15
            next_flags[FLAG_SIGN] = resSign; // RULE16
            next_flags[FLAG_OVF] = aluOverflow; // RULE18
        end
        if (dpWrEn) begin
            unique case (dpWrSel)
                OPD_D0: next_bankReg[bank][IDX_D0] = dpWrData[15:0]; // RULE3
                OPD_D1: next_bankReg[bank][IDX_D1] = dpWrData[15:0];
                OPD_D2: next_bankReg[bank][IDX_D2] = dpWrData[15:0];
                OPD_D3: next_bankReg[bank][IDX_D3] = dpWrData[15:0];
                OPD_A0: next_bankReg[bank][IDX_A0] = dpWrData[15:0]; // RULE5
                OPD_A1: next_bankReg[bank][IDX_A1] = dpWrData[15:0];
                OPD_FB: next_bankReg[bank][IDX_FB] = dpWrData[15:0]; // RULE7
                OPD_SB: next_staticBase = dpWrData[15:0]; // RULE11
                OPD_USP: next_userSp = dpWrData[15:0];
                OPD_ISP: next_interruptSp = dpWrData[15:0];
                OPD_SP: begin
                    if (cpuFlags[FLAG_STACK]) begin // RULE10
                        next_interruptSp = dpWrData[15:0];
                    end else begin
                        next_userSp = dpWrData[15:0];
                    end
                end
                OPD_VECTOR: next_vectorBase = dpWrData[19:0]; // RULE8
                OPD_FLAGS: next_flags = dpWrData[10:0]; // RULE12
                OPD_D0_LO: next_bankReg[bank][IDX_D0][7:0] = dpWrData[7:0]; // RULE3
                OPD_D0_HI: next_bankReg[bank][IDX_D0][15:8] = dpWrData[7:0];
                OPD_D1_LO: next_bankReg[bank][IDX_D1][7:0] = dpWrData[7:0];
                OPD_D1_HI: next_bankReg[bank][IDX_D1][15:8] = dpWrData[7:0];
                OPD_PAIR_LO: begin
                    next_bankReg[bank][IDX_D0] = dpWrData[15:0]; // RULE4
                    next_bankReg[bank][IDX_D2] = dpWrData[31:16];
                end
                OPD_PAIR_HI: begin
                    next_bankReg[bank][IDX_D1] = dpWrData[15:0];
                    next_bankReg[bank][IDX_D3] = dpWrData[31:16];
                end
                OPD_ADDR_PAIR: begin
                    next_bankReg[bank][IDX_A0] = dpWrData[15:0]; // RULE6
                    next_bankReg[bank][IDX_A1] = dpWrData[31:16];
                end
                // PC only moves through its own load and advance ports
                default: ;
            endcase
        end
        // Bus writes come last so a debugger always wins
        if (apbWr) begin
            if (paddr[7:6] == 2'h0) begin
                next_bankReg[paddr[5]][paddr[4:2]] = apbMerged[15:0];
            end else begin
                unique case (paddr)
                    OFS_VECTOR: next_vectorBase = apbMerged[19:0];
                    OFS_USP: next_userSp = apbMerged[15:0];
                    OFS_ISP: next_interruptSp = apbMerged[15:0];
                    OFS_SB: next_staticBase = apbMerged[15:0];
                    // Debug bit is stored as written; keeping it zero is software's job
                    OFS_FLAGS: next_flags = apbMerged[10:0]; // RULE14
                    OFS_SP: begin
                        if (cpuFlags[FLAG_STACK]) begin
                            next_interruptSp = apbMerged[15:0];
                        end else begin
                            next_userSp = apbMerged[15:0];
                        end
                    end
                    OFS_PAIR_LO: begin
                        next_bankReg[bank][IDX_D0] = apbMerged[15:0];
                        next_bankReg[bank][IDX_D2] = apbMerged[31:16];
                    end
                    OFS_PAIR_HI: begin
                        next_bankReg[bank][IDX_D1] = apbMerged[15:0];
                        next_bankReg[bank][IDX_D3] = apbMerged[31:16];
                    end
                    OFS_ADDR_PAIR: begin
                        next_bankReg[bank][IDX_A0] = apbMerged[15:0];
                        next_bankReg[bank][IDX_A1] = apbMerged[31:16];
                    end
                    default: ;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Banked registers
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        for (int b = 0; b < BANKS; b++) begin
            for (int i = 0; i < BANK_REGS; i++) begin
                bankReg[b][i] <= resetn ? next_bankReg[b][i] : WORD_RESET; // RULE19
            end
        end
    end

    // ------------------------------------------------------------
    // Shared registers and flags
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!resetn) begin
            userSp <= WORD_RESET; // RULE19
            interruptSp <= WORD_RESET;
            staticBase <= WORD_RESET;
            vectorBase <= ADDR_RESET;
            cpuFlags <= FLAG_RESET; // RULE19
        end else begin
            userSp <= next_userSp;
            interruptSp <= next_interruptSp;
            staticBase <= next_staticBase;
            vectorBase <= next_vectorBase;
            cpuFlags <= next_flags; // RULE12
        end
    end

    // ------------------------------------------------------------
    // Program counter
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!resetn) begin
            programCounter <= PC_RESET;
        end else if (pcLoad) begin
            programCounter <= pcValue; // RULE9
        end else if (pcAdvance) begin
            programCounter <= programCounter + {17'h00000, pcStep};
        end
    end

    // ------------------------------------------------------------
    // Datapath read port, one cycle behind the select
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!resetn) begin
            dpRdData <= 32'h00000000;
        end else begin
            unique case (dpRdSel)
                OPD_D0: dpRdData <= {16'h0000, bankReg[bank][IDX_D0]}; // RULE1
                OPD_D1: dpRdData <= {16'h0000, bankReg[bank][IDX_D1]};
                OPD_D2: dpRdData <= {16'h0000, bankReg[bank][IDX_D2]};
                OPD_D3: dpRdData <= {16'h0000, bankReg[bank][IDX_D3]};
                OPD_A0: dpRdData <= {16'h0000, bankReg[bank][IDX_A0]};
                OPD_A1: dpRdData <= {16'h0000, bankReg[bank][IDX_A1]};
                OPD_FB: dpRdData <= {16'h0000, bankReg[bank][IDX_FB]};
                OPD_SB: dpRdData <= {16'h0000, staticBase};
                OPD_USP: dpRdData <= {16'h0000, userSp};
                OPD_ISP: dpRdData <= {16'h0000, interruptSp};
                OPD_SP: dpRdData <= {16'h0000, activeSp};
                OPD_VECTOR: dpRdData <= {12'h000, vectorBase};
                OPD_PC: dpRdData <= {12'h000, programCounter};
                OPD_FLAGS: dpRdData <= {21'h000000, cpuFlags};
                OPD_D0_LO: dpRdData <= {24'h000000, bankReg[bank][IDX_D0][7:0]};
                OPD_D0_HI: dpRdData <= {24'h000000, bankReg[bank][IDX_D0][15:8]};
                OPD_D1_LO: dpRdData <= {24'h000000, bankReg[bank][IDX_D1][7:0]};
                OPD_D1_HI: dpRdData <= {24'h000000, bankReg[bank][IDX_D1][15:8]};
                OPD_PAIR_LO: dpRdData <= {bankReg[bank][IDX_D2], bankReg[bank][IDX_D0]};
                OPD_PAIR_HI: dpRdData <= {bankReg[bank][IDX_D3], bankReg[bank][IDX_D1]};
                OPD_ADDR_PAIR: dpRdData <= {bankReg[bank][IDX_A1], bankReg[bank][IDX_A0]};
                default: dpRdData <= 32'h00000000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic quietFlags;
    assign quietFlags = !(dpWrEn && dpWrSel == OPD_FLAGS) && !apbWr;

    a_bank_isolation: assert property (@(posedge clock) disable iff (!resetn) // RULE2
        (dpWrEn && dpWrSel == OPD_D0 && !apbWr)
        |=> bankReg[!$past(bank)][IDX_D0] == $past(bankReg[!bank][IDX_D0]))
        else $error("write leaked into the inactive bank");
    a_zero_flag: assert property (@(posedge clock) disable iff (!resetn) // RULE15
        (aluFlagEn && quietFlags) |=> cpuFlags[FLAG_ZERO] == $past(resZero))
        else $error("zero flag does not follow the result");
    a_sign_flag: assert property (@(posedge clock) disable iff (!resetn) // RULE16
        (aluFlagEn && quietFlags && aluSize == SIZE_WORD)
        |=> cpuFlags[FLAG_SIGN] == $past(aluResult[15]))
        else $error("sign flag does not follow the result");
    a_carry_ovf: assert property (@(posedge clock) disable iff (!resetn) // RULE13
        (aluFlagEn && quietFlags)
        |=> {cpuFlags[FLAG_CARRY], cpuFlags[FLAG_OVF]} == $past({aluCarry, aluOverflow}))
        else $error("carry or overflow not captured");
    a_stack_select: assert property (@(posedge clock) disable iff (!resetn) // RULE10
        (dpRdSel == OPD_SP)
        |=> dpRdData[15:0] == ($past(cpuFlags[FLAG_STACK]) ? $past(interruptSp) : $past(userSp)))
        else $error("wrong stack pointer selected");
    a_pair_read: assert property (@(posedge clock) disable iff (!resetn) // RULE4
        (dpRdSel == OPD_PAIR_LO)
        |=> dpRdData == {$past(bankReg[bank][IDX_D2]), $past(bankReg[bank][IDX_D0])})
        else $error("data pair read out of order");
    a_pc_load: assert property (@(posedge clock) disable iff (!resetn) // RULE9
        pcLoad |=> programCounter == $past(pcValue))
        else $error("program counter did not load");
    a_apb_ready: assert property (@(posedge clock) disable iff (!resetn)
        (apbSetup && apbState == APB_IDLE) |=> pready ##1 !pready)
        else $error("access phase not exactly one cycle");
    a_byte_upper: assert property (@(posedge clock) disable iff (!resetn) // RULE3
        (dpWrEn && dpWrSel == OPD_D0_HI && !apbWr)
        |=> bankReg[$past(bank)][IDX_D0][7:0] == $past(bankReg[bank][IDX_D0][7:0]))
        else $error("upper byte write touched lower byte");

endmodule

// *** dv/cpu_register_file_tb_top.sv ***
`timescale 1ns/1ns
module cpu_register_file_tb_top;
    import cpu_regs_pkg::*;
    localparam logic [19:0] PCR = 20'h0ABC0;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, dpRdData, rdv;
    logic pready, pslverr, errv;
    logic dpWrEn = 1'b0, aluFlagEn = 1'b0, aluCarry = 1'b0, aluOverflow = 1'b0;
    logic pcLoad = 1'b0, pcAdvance = 1'b0;
    logic [31:0] dpWrData = 32'h0, aluResult = 32'h0;
    logic [19:0] pcValue = 20'h0, programCounter;
    logic [2:0] pcStep = 3'h0;
    logic [10:0] cpuFlags;
    operand_t dpRdSel = OPD_D0, dpWrSel = OPD_D0;
    opsize_t aluSize = SIZE_WORD;
    int nMismatch = 0, checkCount = 0, cycles = 0;
    logic [7:0] rowAddr [7] = '{8'h00, 8'h14, 8'h18, 8'h40, 8'h48, 8'h4C, 8'h50};
    logic [31:0] rowData [7] = '{32'h12345678, 32'hFFFFABCD, 32'h0001FB00, 32'hFFFFFFFF,
        32'h00001111, 32'h00002222, 32'hFFFF5B5B};
    logic [31:0] rowExp [7] = '{32'h00005678, 32'h0000ABCD, 32'h0000FB00, 32'h000FFFFF,
        32'h00001111, 32'h00002222, 32'h00005B5B};

    cpu_register_file #(.PC_RESET(PCR)) dut (.clock(clock), .resetn(resetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .dpRdSel(dpRdSel),
        .dpRdData(dpRdData), .dpWrEn(dpWrEn), .dpWrSel(dpWrSel), .dpWrData(dpWrData),
        .aluFlagEn(aluFlagEn), .aluSize(aluSize), .aluResult(aluResult), .aluCarry(aluCarry),
        .aluOverflow(aluOverflow), .pcLoad(pcLoad), .pcValue(pcValue), .pcAdvance(pcAdvance),
        .pcStep(pcStep), .programCounter(programCounter), .cpuFlags(cpuFlags));

    always #2 clock = ~clock;

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic testDone();
        if (nMismatch == 0 && checkCount > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checkCount++;
        if (got !== exp) begin
            nMismatch++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        // The wait ends when pready is high; only the bench timeout catches a stuck pready
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rdv, exp);
    endtask

    task automatic dprd(input operand_t s, input logic [31:0] exp);
        @(posedge clock);
        dpRdSel <= s;
        repeat (2) @(posedge clock);
        chk(dpRdData, exp);
    endtask

    task automatic dpwr(input operand_t s, input logic [31:0] d);
        @(posedge clock);
        dpWrEn <= 1'b1;
        dpWrSel <= s;
        dpWrData <= d;
        @(posedge clock);
        dpWrEn <= 1'b0;
    endtask

    task automatic alu(input opsize_t s, input logic [31:0] r, input logic c, input logic o,
                       input logic [10:0] exp);
        @(posedge clock);
        aluFlagEn <= 1'b1;
        aluSize <= s;
        {aluResult, aluCarry, aluOverflow} <= {r, c, o};
        @(posedge clock);
        aluFlagEn <= 1'b0;
        @(posedge clock);
        chk({21'h0, cpuFlags}, {21'h0, exp});
    endtask

    task automatic pcop(input logic ld, input logic adv, input logic [19:0] v,
                        input logic [2:0] st, input logic [19:0] exp);
        @(posedge clock);
        {pcLoad, pcAdvance, pcValue, pcStep} <= {ld, adv, v, st};
        @(posedge clock);
        {pcLoad, pcAdvance} <= 2'b00;
        @(posedge clock);
        chk({12'h0, programCounter}, {12'h0, exp});
    endtask

    // Hang guard, well above the under two hundred cycles the run needs
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            nMismatch++;
            testDone();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
        chk({12'h0, programCounter}, {12'h0, PCR});
        chk({21'h0, cpuFlags}, 32'h0);
        for (int i = 0; i < 7; i++) begin
            apb(1'b1, rowAddr[i], rowData[i]);
            rd(rowAddr[i], rowExp[i]);
        end
        apb(1'b1, 8'h54, 32'hFFFFFFFD);
        rd(8'h54, 32'h000007FD);
        rd(8'h58, 32'h00002222);
        dprd(OPD_D0, 32'h0);
        apb(1'b1, 8'h20, 32'h0000AAAA);
        apb(1'b1, 8'h28, 32'h0000BBBB);
        rd(8'h5C, 32'hBBBBAAAA);
        dprd(OPD_D0, 32'h0000AAAA);
        apb(1'b1, 8'h54, 32'h0);
        rd(8'h58, 32'h00001111);
        rd(8'h5C, 32'h00005678);
        rd(8'h64, 32'hABCD0000);
        dprd(OPD_D0_HI, 32'h00000056);
        dpwr(OPD_D1, 32'h00009A3C);
        rd(8'h04, 32'h00009A3C);
        dprd(OPD_D1_LO, 32'h0000003C);
        dpwr(OPD_D0_HI, 32'h00000077);
        dprd(OPD_D0, 32'h00007778);
        dpwr(OPD_D0, 32'h0000C0DE);
        rd(8'h20, 32'h0000AAAA);
        dprd(OPD_PAIR_LO, 32'h0000C0DE);
        dprd(OPD_SP, 32'h00001111);
        apb(1'b0, 8'h1C, 32'h0);
        chk({31'h0, errv}, 32'h1);
        apb(1'b1, 8'h44, 32'h00000004);
        chk({31'h0, errv}, 32'h1);
        chk({12'h0, programCounter}, {12'h0, PCR});
        alu(SIZE_WORD, 32'h00010000, 1'b1, 1'b0, 11'h005);
        alu(SIZE_BYTE, 32'h00000080, 1'b0, 1'b1, 11'h028);
        alu(SIZE_LONG, 32'h00000100, 1'b0, 1'b0, 11'h000);
        pcop(1'b1, 1'b0, 20'h12345, 3'h0, 20'h12345);
        pcop(1'b0, 1'b1, 20'h0, 3'h3, 20'h12348);
        pcop(1'b1, 1'b1, 20'h00100, 3'h2, 20'h00100);
        // Reset again in mid-run: one edge low must restore the PC and the user stack pointer
        resetn <= 1'b0;
        @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
        chk({12'h0, programCounter}, {12'h0, PCR});
        rd(8'h48, 32'h0);
        testDone();
    end
endmodule
